/* File: design/dasy_top.sv */
/*
  DMA channel trigger logic for an on-chip ADC: pending trigger and
  overflow flags, sync check against wrap and transfer start, re-align
  by a forced wrap, overrun interrupt, and the ADC trim and reference
  registers.
  Assumes the ADC sequencer logic runs on mclk and drives one-cycle
  trigger and sync pulses, and that a bus arbiter grants bursts.
*/
// The implementer's own choices: the address map and the plain strobed port.
// Functional notes
// - With sync enabled, the channel locks to sequencer A end events during continuous override.
// - Each sync is checked against a wrap or a transfer start at the burst it triggers.
// - A sync that meets neither makes the channel perform a wrap to re-align.
// - A trigger sets the pending trigger flag.
// - The pending flag clears when the burst serving the trigger begins.
// - A trigger that finds the flag still set before its burst is discarded, not queued.
// - A discarded trigger sets the overflow flag.
// - With the overrun interrupt enabled, overflow raises the channel interrupt request.
// - The offset trim is a nine-bit two's-complement field driven to the analog front end.
`timescale 1ns/1ns
`default_nettype none
`include "dasy_defs.svh"

module dasy_top
  import dasy_pkg::*;
#(
  parameter int CNT_W = `DASY_CNT_W,
  parameter int RSC_W = `DASY_RSC_W
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [`DASY_ADDR_W-1:0] reg_addr,
  input wire logic [`DASY_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`DASY_DATA_W-1:0] reg_rdata,
  input wire logic seq_a_end_event,
  input wire logic adc_sync,
  input wire logic burst_grant,
  output logic burst_start,
  output dasy_evt_t chan_evt,
  output logic overrun_irq,
  output logic signed [`DASY_TRIM_W-1:0] adc_offset_trim,
  output logic [`DASY_REFS_W-1:0] adc_reference_select
);

  dasy_ctrl_t ctrl_r;
  dasy_ctrl_t ctrl_nxt;
  logic [CNT_W-1:0] wrap_size_r;
  logic [CNT_W-1:0] wrap_size_nxt;
  logic [CNT_W-1:0] xfer_size_r;
  logic [CNT_W-1:0] xfer_size_nxt;
  logic [`DASY_TRIM_W-1:0] trim_r;
  logic [`DASY_TRIM_W-1:0] trim_nxt;
  logic [`DASY_REFS_W-1:0] refs_r;
  logic [`DASY_REFS_W-1:0] refs_nxt;
  logic [`DASY_DATA_W-1:0] rdata_r;
  logic [`DASY_DATA_W-1:0] rdata_nxt;
  logic pend_r;
  logic pend_nxt;
  logic tag_r;
  logic tag_nxt;
  logic [RSC_W-1:0] rsc_cnt_r;
  logic [RSC_W-1:0] rsc_cnt_nxt;
  dasy_evt_t evt_r;
  dasy_evt_t evt_nxt;
  logic trig_ok;
  logic trig_lost;
  logic wrap_zero;
  logic xfer_zero;
  logic resync_now;
  logic ovf_flag;
  logic ovf_clr;
  logic wr_ctrl;

  // Address decode of the register port.
  assign wr_ctrl = reg_wr && (reg_addr == `DASY_OFF_CTRL);
  assign ovf_clr = wr_ctrl && reg_wdata[`DASY_CTRL_CLRO];

  // Software registers; trim and reference hold zero until firmware loads them.
  always_comb begin
    ctrl_nxt = ctrl_r;
    wrap_size_nxt = wrap_size_r;
    xfer_size_nxt = xfer_size_r;
    trim_nxt = trim_r;
    refs_nxt = refs_r;
    if (reg_wr) begin
      case (reg_addr)
        `DASY_OFF_CTRL: begin
          ctrl_nxt.run_en = reg_wdata[`DASY_CTRL_RUN];
          ctrl_nxt.sync_en = reg_wdata[`DASY_CTRL_SYNC];
          ctrl_nxt.ovr_int_en = reg_wdata[`DASY_CTRL_OVIE];
        end
        `DASY_OFF_WRAP: wrap_size_nxt = reg_wdata[CNT_W-1:0];
        `DASY_OFF_XFER: xfer_size_nxt = reg_wdata[CNT_W-1:0];
        `DASY_OFF_TRIM: trim_nxt = reg_wdata[`DASY_TRIM_W-1:0];
        `DASY_OFF_REFS: refs_nxt = reg_wdata[`DASY_REFS_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Register the software registers.
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_r <= `DASY_RST_CTRL;
      wrap_size_r <= `DASY_RST_SIZE;
      xfer_size_r <= `DASY_RST_SIZE;
      trim_r <= `DASY_RST_TRIM;
      refs_r <= `DASY_RST_REFS;
    end else begin
      ctrl_r <= ctrl_nxt;
      wrap_size_r <= wrap_size_nxt;
      xfer_size_r <= xfer_size_nxt;
      trim_r <= trim_nxt;
      refs_r <= refs_nxt;
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads give zero.
  always_comb begin
    rdata_nxt = '0;
    if (reg_rd) begin
      case (reg_addr)
        `DASY_OFF_CTRL: begin
          rdata_nxt[`DASY_CTRL_RUN] = ctrl_r.run_en;
          rdata_nxt[`DASY_CTRL_SYNC] = ctrl_r.sync_en;
          rdata_nxt[`DASY_CTRL_OVIE] = ctrl_r.ovr_int_en;
          rdata_nxt[`DASY_CTRL_PEND] = pend_r;
          rdata_nxt[`DASY_CTRL_OVF] = ovf_flag;
          rdata_nxt[`DASY_CTRL_TAG] = tag_r;
        end
        `DASY_OFF_STAT: rdata_nxt[RSC_W-1:0] = rsc_cnt_r;
        `DASY_OFF_WRAP: rdata_nxt[CNT_W-1:0] = wrap_size_r;
        `DASY_OFF_XFER: rdata_nxt[CNT_W-1:0] = xfer_size_r;
        `DASY_OFF_TRIM: rdata_nxt = {{(`DASY_DATA_W-`DASY_TRIM_W){trim_r[`DASY_TRIM_W-1]}},
                                     trim_r};
        `DASY_OFF_REFS: rdata_nxt[`DASY_REFS_W-1:0] = refs_r;
        default: rdata_nxt = '0;
      endcase
    end
  end

  // Register the read data.
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // A burst may only start for a pending trigger on a running channel.
  assign burst_start = ctrl_r.run_en && pend_r && burst_grant;
  // A trigger is taken when no earlier one still waits for its burst.
  assign trig_ok = seq_a_end_event && (!pend_r || burst_start);
  assign trig_lost = seq_a_end_event && pend_r && !burst_start;
  // A tagged burst that is neither a wrap nor a transfer start is out of step.
  assign resync_now = burst_start && ctrl_r.sync_en && tag_r
                      && !(wrap_zero || xfer_zero);

  // Pending flag and sync tag; a new trigger in the burst cycle re-arms them.
  always_comb begin
    pend_nxt = pend_r;
    tag_nxt = tag_r;
    if (trig_ok) begin
      pend_nxt = 1'b1;
      tag_nxt = adc_sync;
    end else if (burst_start) begin
      pend_nxt = 1'b0;
      tag_nxt = 1'b0;
    end
  end

  // Event outputs and the count of re-alignments.
  always_comb begin
    evt_nxt.xfer_start = burst_start && xfer_zero;
    evt_nxt.wrap = burst_start && (wrap_zero || resync_now);
    evt_nxt.resync = resync_now;
    rsc_cnt_nxt = rsc_cnt_r;
    if (resync_now) begin
      rsc_cnt_nxt = rsc_cnt_r + {{(RSC_W-1){1'b0}}, 1'b1};
    end
  end

  // Register channel state.
  always_ff @(posedge mclk) begin
    if (srst) begin
      pend_r <= 1'b0;
      tag_r <= 1'b0;
      evt_r <= '0;
      rsc_cnt_r <= '0;
    end else begin
      pend_r <= pend_nxt;
      tag_r <= tag_nxt;
      evt_r <= evt_nxt;
      rsc_cnt_r <= rsc_cnt_nxt;
    end
  end

  // Wrap period counter; a re-align reloads it as a real wrap would.
  dasy_cnt #(
    .W(CNT_W)
  ) u_wrap_cnt (
    .mclk(mclk),
    .srst(srst),
    .step(burst_start),
    .force_load(resync_now),
    .size(wrap_size_r),
    .zero(wrap_zero)
  );

  // Transfer length counter; zero means the next burst opens a transfer.
  dasy_cnt #(
    .W(CNT_W)
  ) u_xfer_cnt (
    .mclk(mclk),
    .srst(srst),
    .step(burst_start),
    .force_load(1'b0),
    .size(xfer_size_r),
    .zero(xfer_zero)
  );

  // Overflow stays until software writes one to its clear bit.
  dasy_flag u_ovf (
    .mclk(mclk),
    .srst(srst),
    .set(trig_lost),
    .clr(ovf_clr),
    .flag(ovf_flag)
  );

  // Outputs; the interrupt is a level from flops so it cannot glitch.
  assign overrun_irq = ovf_flag && ctrl_r.ovr_int_en;
  assign chan_evt = evt_r;
  assign reg_rdata = rdata_r;
  assign adc_offset_trim = trim_r;
  assign adc_reference_select = refs_r;

  property p_pend_set;
    @(posedge mclk) disable iff (srst) seq_a_end_event |=> pend_r;
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("pending flag not set");

  property p_pend_clr;
    @(posedge mclk) disable iff (srst) (burst_start && !seq_a_end_event) |=> !pend_r;
  endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("pending flag not cleared");

  property p_no_queue;
    @(posedge mclk) disable iff (srst)
      trig_lost ##1 (burst_start && !seq_a_end_event) |=> !pend_r ##1 !burst_start;
  endproperty
  a_no_queue: assert property (p_no_queue) else $error("lost trigger was queued");

  property p_ovf_set;
    @(posedge mclk) disable iff (srst) trig_lost |=> ovf_flag;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");

  property p_irq;
    @(posedge mclk) disable iff (srst)
      (trig_lost && ctrl_r.ovr_int_en && !reg_wr) |=> overrun_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("overrun interrupt missing");

  property p_ovf_hold;
    @(posedge mclk) disable iff (srst) (ovf_flag && !ovf_clr) |=> ovf_flag;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow dropped");

  property p_resync;
    @(posedge mclk) disable iff (srst)
      (burst_start && ctrl_r.sync_en && tag_r && !wrap_zero && !xfer_zero)
      |=> chan_evt.resync && chan_evt.wrap;
  endproperty
  a_resync: assert property (p_resync) else $error("no re-align wrap");

  property p_sync_ok;
    @(posedge mclk) disable iff (srst)
      (burst_start && (wrap_zero || xfer_zero)) |=> !chan_evt.resync;
  endproperty
  a_sync_ok: assert property (p_sync_ok) else $error("spurious re-align");

  property p_sync_off;
    @(posedge mclk) disable iff (srst) (burst_start && !ctrl_r.sync_en) |=> !chan_evt.resync;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("re-align while sync off");

  property p_trim;
    @(posedge mclk) disable iff (srst)
      (reg_wr && reg_addr == `DASY_OFF_TRIM)
      |=> adc_offset_trim == $past(reg_wdata[`DASY_TRIM_W-1:0]);
  endproperty
  a_trim: assert property (p_trim) else $error("trim not loaded");

  property p_cv_lost;
    @(posedge mclk) disable iff (srst) trig_lost ##1 overrun_irq;
  endproperty
  c_cv_lost: cover property (p_cv_lost);

  property p_cv_resync;
    @(posedge mclk) disable iff (srst) resync_now ##1 chan_evt.resync;
  endproperty
  c_cv_resync: cover property (p_cv_resync);

  property p_cv_xfer;
    @(posedge mclk) disable iff (srst) burst_start && xfer_zero && tag_r;
  endproperty
  c_cv_xfer: cover property (p_cv_xfer);

endmodule : dasy_top

`default_nettype wire

/* File: design/dasy_defs.svh */
/*
  Offsets, field positions and reset values of the ADC sync and overrun block.
  Assumes a 16-bit register port with word offsets given in bytes.
*/
`ifndef DASY_DEFS_SVH
`define DASY_DEFS_SVH

`define DASY_DATA_W 16
`define DASY_ADDR_W 8

`define DASY_OFF_CTRL 8'h00
`define DASY_OFF_STAT 8'h04
`define DASY_OFF_WRAP 8'h08
`define DASY_OFF_XFER 8'h0C
`define DASY_OFF_TRIM 8'h10
`define DASY_OFF_REFS 8'h14

`define DASY_CTRL_RUN 0
`define DASY_CTRL_SYNC 1
`define DASY_CTRL_OVIE 2
`define DASY_CTRL_CLRO 15
`define DASY_CTRL_PEND 8
`define DASY_CTRL_OVF 9
`define DASY_CTRL_TAG 10

`define DASY_TRIM_W 9
`define DASY_REFS_W 2
`define DASY_CNT_W 16
`define DASY_RSC_W 8

`define DASY_RST_CTRL 3'h0
`define DASY_RST_SIZE 16'h0000
`define DASY_RST_TRIM 9'h000
`define DASY_RST_REFS 2'h0

`endif

/* File: design/dasy_pkg.sv */
/*
  Types shared by the ADC sync and overrun block.
  Assumes dasy_defs.svh is on the include path.
*/
`include "dasy_defs.svh"

package dasy_pkg;

  // Software controls of the channel.
  typedef struct packed {
    logic ovr_int_en;
    logic sync_en;
    logic run_en;
  } dasy_ctrl_t;

  // Channel events of one burst start, registered.
  typedef struct packed {
    logic resync;
    logic wrap;
    logic xfer_start;
  } dasy_evt_t;

endpackage : dasy_pkg

/* File: design/dasy_flag.sv */
/*
  A sticky flag: hardware sets it, software clears it, a set in the
  clearing cycle wins.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none

module dasy_flag (
  input wire logic mclk,
  input wire logic srst,
  input wire logic set,
  input wire logic clr,
  output logic flag
);

  logic flag_r;
  logic flag_nxt;

  // Set has priority so an event in the clear cycle is kept.
  always_comb begin
    flag_nxt = flag_r;
    if (set) begin
      flag_nxt = 1'b1;
    end else if (clr) begin
      flag_nxt = 1'b0;
    end
  end

  // Register the flag.
  always_ff @(posedge mclk) begin
    if (srst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;

endmodule : dasy_flag

`default_nettype wire

/* File: design/dasy_cnt.sv */
/*
  Burst down-counter with reload, used for the wrap period and the
  transfer length.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none

module dasy_cnt #(
  parameter int W = 16
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic step,
  input wire logic force_load,
  input wire logic [W-1:0] size,
  output logic zero
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // A burst at zero, or a forced reload, starts a new period.
  always_comb begin
    cnt_nxt = cnt_r;
    if (step) begin
      if ((cnt_r == '0) || force_load) begin
        cnt_nxt = size;
      end else begin
        cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Register the count.
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign zero = (cnt_r == '0);

endmodule : dasy_cnt

`default_nettype wire

/* File: verification/dasy_seq_model.sv */
/*
  Behavioural model of ADC sequencer A converting continuously in override mode.
  Assumes the bench pulses fire for one cycle per completed sequence.
*/
`timescale 1ns/1ns
`default_nettype none

module dasy_seq_model #(
  parameter int SLOTS = 3,
  parameter int LEN = 1
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic fire,
  output var logic seq_a_end_event,
  output var logic adc_sync
);
  int ptr;

  // The slot pointer runs on across sequences, so sync only shows when it comes round to zero.
  always @(posedge mclk) begin
    if (srst) begin
      ptr <= 0;
      seq_a_end_event <= 1'b0;
      adc_sync <= 1'b0;
    end else begin
      seq_a_end_event <= fire;
      adc_sync <= fire && (ptr == 0);
      if (fire) begin
        ptr <= (ptr + LEN) % SLOTS;
      end
    end
  end
endmodule : dasy_seq_model

`default_nettype wire

/* File: verification/dasy_top_tb_top.sv */
/*
  Self-checking bench of the ADC sync and overrun block.
  Assumes the sequencer model beside it and no other driver of the trigger inputs.
*/
`timescale 1ns/1ns
`default_nettype none
`include "dasy_defs.svh"

module dasy_top_tb_top;
  import dasy_pkg::*;

  typedef struct packed {
    logic [7:0] a;
    logic [15:0] w;
    logic [15:0] r;
  } dasy_row_t;

  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic seq_a_end_event;
  logic adc_sync;
  logic burst_grant = 1'b0;
  logic burst_start;
  dasy_evt_t chan_evt;
  logic overrun_irq;
  logic signed [8:0] adc_offset_trim;
  logic [1:0] adc_reference_select;
  logic fire = 1'b0;
  logic [15:0] d;
  logic [15:0] nb;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  dasy_row_t rows[5];
  logic [2:0] ev_exp[5];
  logic [7:0] rst_addr[4];

  // Half period of 4 ns gives the 125 MHz clock.
  always #4 mclk = ~mclk;

  dasy_seq_model #(.SLOTS(3), .LEN(1)) seq (.mclk(mclk), .srst(srst), .fire(fire),
    .seq_a_end_event(seq_a_end_event), .adc_sync(adc_sync));

  dasy_top DUT (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .seq_a_end_event(seq_a_end_event), .adc_sync(adc_sync), .burst_grant(burst_grant),
    .burst_start(burst_start), .chan_evt(chan_evt), .overrun_irq(overrun_irq),
    .adc_offset_trim(adc_offset_trim), .adc_reference_select(adc_reference_select));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // The strobe drops a cycle before any next access, so no signal is set twice in one step.
  task automatic wr(input logic [7:0] a, input logic [15:0] w);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // One sequence end, its burst one cycle after the trigger, the events a cycle later.
  task automatic burst(input logic [2:0] exp);
    @(posedge mclk) fire <= 1'b1;
    @(posedge mclk) fire <= 1'b0;
    @(posedge mclk);
    #1 chk({15'h0, burst_start}, 16'h0001);
    @(posedge mclk);
    #1 chk({13'h0, chan_evt}, {13'h0, exp});
  endtask : burst

  // Cuts a hang short well above the hundred or so cycles the run needs.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    rows = '{'{`DASY_OFF_TRIM, 16'h01FF, 16'hFFFF}, '{`DASY_OFF_TRIM, 16'h0100, 16'hFF00},
      '{`DASY_OFF_TRIM, 16'h00FF, 16'h00FF}, '{`DASY_OFF_REFS, 16'h0003, 16'h0003},
      '{8'h20, 16'hFFFF, 16'h0000}};
    ev_exp = '{3'b011, 3'b000, 3'b000, 3'b110, 3'b000};
    rst_addr = '{`DASY_OFF_CTRL, `DASY_OFF_STAT, `DASY_OFF_TRIM, `DASY_OFF_REFS};
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    // Reset values of the control, status, trim and reference registers and the trim output.
    foreach (rst_addr[i]) begin
      rd(rst_addr[i], d);
      chk(d, 16'h0000);
    end
    chk({7'h0, adc_offset_trim}, 16'h0000);
    // Register rows: write, read back, and see the analog outputs follow.
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk(d, rows[i].r);
      if (rows[i].a == `DASY_OFF_TRIM) chk({{7{adc_offset_trim[8]}}, adc_offset_trim}, rows[i].r);
      if (rows[i].a == `DASY_OFF_REFS) chk({14'h0, adc_reference_select}, rows[i].r);
    end
    // Five bursts; the fourth carries a sync that meets neither wrap nor transfer start.
    wr(`DASY_OFF_WRAP, 16'h0003);
    wr(`DASY_OFF_XFER, 16'h0007);
    wr(`DASY_OFF_CTRL, 16'h0007);
    @(posedge mclk) burst_grant <= 1'b1;
    foreach (ev_exp[i]) burst(ev_exp[i]);
    rd(`DASY_OFF_STAT, d);
    chk(d, 16'h0001);
    // Two triggers back to back with no grant: the second is lost.
    @(posedge mclk) burst_grant <= 1'b0;
    fire <= 1'b1;
    repeat (2) @(posedge mclk);
    fire <= 1'b0;
    repeat (3) @(posedge mclk);
    rd(`DASY_OFF_CTRL, d);
    chk(d, 16'h0307);
    chk({15'h0, overrun_irq}, 16'h0001);
    wr(`DASY_OFF_CTRL, 16'h0003);
    #1 chk({15'h0, overrun_irq}, 16'h0000);
    wr(`DASY_OFF_CTRL, 16'h0007);
    #1 chk({15'h0, overrun_irq}, 16'h0001);
    // Only the one kept trigger may earn a burst.
    @(posedge mclk) burst_grant <= 1'b1;
    nb = 16'h0000;
    #1;
    repeat (4) begin
      nb = nb + {15'h0, burst_start};
      @(posedge mclk);
      #1;
    end
    chk(nb, 16'h0001);
    rd(`DASY_OFF_CTRL, d);
    chk(d, 16'h0207);
    wr(`DASY_OFF_CTRL, 16'h8007);
    rd(`DASY_OFF_CTRL, d);
    chk(d, 16'h0007);
    chk({15'h0, overrun_irq}, 16'h0000);
    // A stopped channel keeps its trigger pending; restarting it with sync off serves it.
    wr(`DASY_OFF_CTRL, 16'h0004);
    @(posedge mclk) fire <= 1'b1;
    @(posedge mclk) fire <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk({15'h0, burst_start}, 16'h0000);
    rd(`DASY_OFF_CTRL, d);
    chk(d, 16'h0104);
    wr(`DASY_OFF_CTRL, 16'h0005);
    #1 chk({15'h0, burst_start}, 16'h0001);
    @(posedge mclk);
    #1 chk({13'h0, chan_evt}, 16'h0000);
    give_verdict();
  end
endmodule : dasy_top_tb_top

`default_nettype wire
